// ==== include/nco_ctrl_pkg.sv ====
// Package of constants for the channel oscillator control block.
// Assumes an APB master with 32-bit data and one register per aligned word.
// Overview of operation
// - Register at offset 0x09 holds path A frequency word bits 31 to 16.
// - Path A frequency word adds into the path A accumulator every cycle that clk_en is high.
// - Dual-path mode adds path B word every cycle that clk_en is high; halves at 0x0A and 0x0B.
// - Path A phase offset at 0x0C is added to accumulator output.
// - Dual-path mode adds path B phase offset at 0x0D to path B output.
// - Writes to 0x08 to 0x0D fill shadow copies; only a sync event moves them to active use.
// - Registers decode on page two times channel plus one, one copy per channel.
// - Register at offset 0x08 holds path A frequency word bits 15 to 0.
package nco_ctrl_pkg;
    localparam int          REG_W        = 16;
    localparam int          ACC_W        = 32;
    localparam int          PAGE_LSB     = 8;
    localparam int          PAGE_W       = 4;
    localparam int          IDX_W        = 6;
    localparam logic [5:0]  IDX_FA_LOW   = 6'h08;
    localparam logic [5:0]  IDX_FA_HIGH  = 6'h09;
    localparam logic [5:0]  IDX_FB_LOW   = 6'h0A;
    localparam logic [5:0]  IDX_FB_HIGH  = 6'h0B;
    localparam logic [5:0]  IDX_PH_A     = 6'h0C;
    localparam logic [5:0]  IDX_PH_B     = 6'h0D;
    localparam logic [5:0]  IDX_CTRL     = 6'h3E;
    localparam logic [5:0]  IDX_STATUS   = 6'h3F;
    localparam logic [15:0] FIELD_RESET  = 16'h0000;
    localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
    localparam int          CTRL_DUAL    = 0;
    localparam int          CTRL_SYNC    = 1;
    localparam int          STAT_PEND    = 0;
    localparam int          STAT_DUAL    = 1;
endpackage

// ==== include/nco_cfg_if.sv ====
// Interface carrying the active oscillator settings to the accumulator module.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface nco_cfg_if;
    logic [31:0] freq_a;
    logic [31:0] freq_b;
    logic [15:0] shift_a;
    logic [15:0] shift_b;
    logic        dual;
    modport src (output freq_a, output freq_b, output shift_a, output shift_b, output dual);
    modport dst (input freq_a, input freq_b, input shift_a, input shift_b, input dual);
endinterface

// ==== rtl/nco_phase_core.sv ====
// Phase accumulators for path A and path B with fixed phase offsets.
// Assumes the settings on the interface are already the active copies.
`timescale 1ns/1ns
module nco_phase_core (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // Settings
    nco_cfg_if.dst           cfg,
    // Phase out
    output logic      [15:0] phase_a,
    output logic      [15:0] phase_b
);
    logic [31:0] acc_a_reg;
    logic [31:0] acc_a_next;
    logic [31:0] acc_b_reg;
    logic [31:0] acc_b_next;
    logic [15:0] ph_a_reg;
    logic [15:0] ph_a_next;
    logic [15:0] ph_b_reg;
    logic [15:0] ph_b_next;

    always_comb begin
        acc_a_next = acc_a_reg + cfg.freq_a;
        acc_b_next = cfg.dual ? acc_b_reg + cfg.freq_b : nco_ctrl_pkg::ACC_RESET;
        ph_a_next  = acc_a_reg[31:16] + cfg.shift_a;
        ph_b_next  = cfg.dual ? acc_b_reg[31:16] + cfg.shift_b : nco_ctrl_pkg::FIELD_RESET;
    end

    // Path B stays cleared in single-path mode so it starts from zero phase when enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_a_reg <= nco_ctrl_pkg::ACC_RESET;
            acc_b_reg <= nco_ctrl_pkg::ACC_RESET;
            ph_a_reg  <= nco_ctrl_pkg::FIELD_RESET;
            ph_b_reg  <= nco_ctrl_pkg::FIELD_RESET;
        end else if (clk_en) begin
            acc_a_reg <= acc_a_next;
            acc_b_reg <= acc_b_next;
            ph_a_reg  <= ph_a_next;
            ph_b_reg  <= ph_b_next;
        end
    end

    assign phase_a = ph_a_reg;
    assign phase_b = ph_b_reg;
endmodule

// ==== rtl/ddc_nco_phase_control.sv ====
// Top of the channel oscillator control: APB register slave, shadow and active
// copies, and the phase accumulators. Assumes a single APB master on pclk.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module ddc_nco_phase_control #(
    parameter int CHANNEL = 0
) (
    // Clock, reset and enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sync event and phase outputs
    input  wire logic        sync_in,
    output logic      [15:0] phase_a,
    output logic      [15:0] phase_b
);
    localparam logic [3:0] PAGE = 4'(2 * CHANNEL + 1);

    initial begin
        if (CHANNEL < 0 || CHANNEL > 7) begin
            $error("CHANNEL must lie between 0 and 7");
        end
    end

    nco_cfg_if cfg ();

    logic [15:0] sh_reg [6];
    logic [15:0] sh_next [6];
    logic [15:0] act_reg [6];
    logic [15:0] act_next [6];
    logic        dual_reg;
    logic        dual_next;
    logic        pend_reg;
    logic        pend_next;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    logic        rdy_reg;
    logic        rdy_next;
    logic        err_reg;
    logic        err_next;
    logic        wr_go;
    logic        rd_go;
    logic        on_page;
    logic [5:0]  idx;
    logic        do_sync;

    // Shared decode: shadow slot number for a register index, or 7 if none.
    function automatic logic [2:0] slot_of(input logic [5:0] i);
        if (i >= nco_ctrl_pkg::IDX_FA_LOW && i <= nco_ctrl_pkg::IDX_PH_B) begin
            return 3'(i - nco_ctrl_pkg::IDX_FA_LOW);
        end
        return 3'h7;
    endfunction

    assign idx     = paddr[7:2];
    assign on_page = paddr[11:8] == PAGE && paddr[1:0] == 2'h0 && paddr[31:12] == 20'h00000;
    assign wr_go   = psel && penable && !rdy_reg && pwrite;
    assign rd_go   = psel && penable && !rdy_reg && !pwrite;
    assign do_sync = sync_in || (wr_go && on_page && idx == nco_ctrl_pkg::IDX_CTRL
                                 && pwdata[nco_ctrl_pkg::CTRL_SYNC]);

    always_comb begin
        sh_next   = sh_reg;
        act_next  = act_reg;
        dual_next = dual_reg;
        pend_next = pend_reg;
        rd_next   = rd_reg;
        rdy_next  = 1'b0;
        err_next  = 1'b0;
        if (psel && penable && !rdy_reg) begin
            rdy_next = 1'b1;
            err_next = !on_page || (slot_of(idx) == 3'h7 && idx != nco_ctrl_pkg::IDX_CTRL
                                    && idx != nco_ctrl_pkg::IDX_STATUS);
        end
        if (wr_go && on_page && slot_of(idx) != 3'h7) begin
            sh_next[slot_of(idx)] = pwdata[15:0];
            pend_next = 1'b1;
        end
        if (wr_go && on_page && idx == nco_ctrl_pkg::IDX_CTRL) begin
            dual_next = pwdata[nco_ctrl_pkg::CTRL_DUAL];
        end
        if (rd_go) begin
            rd_next = 32'h0000_0000;
            if (on_page && slot_of(idx) != 3'h7) begin
                rd_next[15:0] = sh_reg[slot_of(idx)];
            end else if (on_page && idx == nco_ctrl_pkg::IDX_CTRL) begin
                rd_next[nco_ctrl_pkg::CTRL_DUAL] = dual_reg;
            end else if (on_page && idx == nco_ctrl_pkg::IDX_STATUS) begin
                rd_next[nco_ctrl_pkg::STAT_PEND] = pend_reg;
                rd_next[nco_ctrl_pkg::STAT_DUAL] = dual_reg;
            end
        end
        // A sync copies the shadows seen before this cycle's write lands.
        if (do_sync) begin
            act_next  = sh_reg;
            pend_next = wr_go && on_page && slot_of(idx) != 3'h7;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 6; k++) begin
                sh_reg[k]  <= nco_ctrl_pkg::FIELD_RESET;
                act_reg[k] <= nco_ctrl_pkg::FIELD_RESET;
            end
            dual_reg <= 1'b0;
            pend_reg <= 1'b0;
            rd_reg   <= 32'h0000_0000;
            rdy_reg  <= 1'b0;
            err_reg  <= 1'b0;
        end else if (clk_en) begin
            sh_reg   <= sh_next;
            act_reg  <= act_next;
            dual_reg <= dual_next;
            pend_reg <= pend_next;
            rd_reg   <= rd_next;
            rdy_reg  <= rdy_next;
            err_reg  <= err_next;
        end
    end

    assign cfg.freq_a  = {act_reg[1], act_reg[0]};
    assign cfg.freq_b  = {act_reg[3], act_reg[2]};
    assign cfg.shift_a = act_reg[4];
    assign cfg.shift_b = act_reg[5];
    assign cfg.dual    = dual_reg;

    assign prdata  = rd_reg;
    assign pready  = rdy_reg;
    assign pslverr = err_reg;

    nco_phase_core u_core (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .cfg     (cfg.dst),
        .phase_a (phase_a),
        .phase_b (phase_b)
    );
endmodule

// ==== sim/nco_ctrl_sva.sv ====
// Checker for the channel oscillator control ports.
// Assumes it is bound onto the top module and shares its channel number.
`timescale 1ns/1ns
module nco_ctrl_sva #(
    parameter int CHANNEL = 0
) (
    // All ports of the watched block
    input wire logic        pclk, presetn, clk_en, psel, penable, pwrite, sync_in,
    input wire logic        pready, pslverr,
    input wire logic [31:0] paddr, pwdata, prdata,
    input wire logic [15:0] phase_a, phase_b
);
    localparam logic [23:0] PG = 24'(2 * CHANNEL + 1);
    wire                    acc = psel && penable && !pready && clk_en;
    freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(phase_a) && $stable(phase_b)) else $error("phase moved while frozen");
    answer_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc |=> pready) else $error("access not answered in one cycle");
    ready_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> $past(psel && penable)) else $error("ready without access");
    err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");
    off_page_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && paddr[31:8] != PG |=> pslverr) else $error("off-page access accepted");
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && paddr[31:8] == PG && paddr[1:0] == 2'h0 && paddr[7:2] inside {[6'h08:6'h0D]}
        |=> !pslverr) else $error("mapped register refused");
    err_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
    reset_zero_a: assert property (@(posedge pclk)
        !presetn |-> phase_a == 16'h0 && phase_b == 16'h0 && !pready) else $error("reset not zero");
endmodule
bind ddc_nco_phase_control nco_ctrl_sva #(.CHANNEL(CHANNEL)) i_nco_ctrl_sva (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .sync_in(sync_in), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .phase_a(phase_a), .phase_b(phase_b));

// ==== sim/test_ddc_nco_phase_control.sv ====
// Self-checking bench for the channel oscillator control block.
// Assumes channel 3, so the block answers on page 0x07.
`timescale 1ns/1ns
module test_ddc_nco_phase_control;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic        sync_in = 0, pready, pslverr, e;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r;
    logic [15:0] phase_a, phase_b, p0, b0;
    int          fails = 0, check_count = 0, cyc = 0;
    // Path B word is twice path A, so sixteen steps give exact whole deltas.
    logic [5:0]  row_idx [6] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D};
    logic [15:0] row_val [6] = '{16'h4000, 16'h0001, 16'h8000, 16'h0002, 16'h1200, 16'h3400};
    ddc_nco_phase_control #(.CHANNEL(3)) i_ddc_nco_phase_control (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_in(sync_in), .phase_a(phase_a), .phase_b(phase_b));
    task automatic chk_data(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chk_flag(input string nm, input logic ex, input logic got);
        check_count++;
        if (got !== ex) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] pg, input logic [5:0] ix,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {16'h0000, pg, ix, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Ready is looked at where it has settled, and taken at the next rising edge.
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) fails++;
        r = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic results;
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #4 pclk = ~pclk;
    // A hang must still end in the report, so a stuck wait counts as a mismatch.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(0, 8'h07, row_idx[i], 0);
            chk_data("reset value", 32'h0, r);
            apb(1, 8'h07, row_idx[i], {16'h0000, row_val[i]});
            apb(0, 8'h07, row_idx[i], 0);
            chk_data("readback", {16'h0000, row_val[i]}, r);
            chk_flag("mapped error", 1'b0, e);
        end
        apb(1, 8'h07, 6'h3E, 32'h1);
        chk_data("phase a before sync", 32'h0, {16'h0, phase_a});
        chk_data("phase b before sync", 32'h0, {16'h0, phase_b});
        apb(0, 8'h07, 6'h3F, 0);
        chk_data("status pending", 32'h3, r);
        sync_in <= 1'b1;
        @(posedge pclk);
        sync_in <= 1'b0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        p0 = phase_a;
        b0 = phase_b;
        chk_flag("offset a", 1'b1, 16'(p0 - 16'h1200) < 16'h0020);
        chk_flag("offset b", 1'b1, 16'(b0 - 16'h3400) < 16'h0040);
        repeat (16) @(posedge pclk);
        @(negedge pclk);
        chk_data("step a", 32'd20, {16'h0, 16'(phase_a - p0)});
        chk_data("step b", 32'd40, {16'h0, 16'(phase_b - b0)});
        @(posedge pclk);
        clk_en <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        p0 = phase_a;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk_data("frozen", {16'h0, p0}, {16'h0, phase_a});
        @(posedge pclk);
        clk_en <= 1'b1;
        apb(0, 8'h07, 6'h3F, 0);
        chk_data("status after sync", 32'h2, r);
        apb(1, 8'h07, 6'h09, 32'h0000_0005);
        apb(1, 8'h07, 6'h3E, 32'h2);
        apb(0, 8'h07, 6'h3F, 0);
        chk_data("status soft sync", 32'h0, r);
        apb(0, 8'h07, 6'h3E, 0);
        chk_data("control read", 32'h0, r);
        apb(1, 8'h07, 6'h3E, 32'h0);
        repeat (2) @(posedge pclk);
        chk_data("phase b single", 32'h0, {16'h0, phase_b});
        apb(0, 8'h05, 6'h08, 0);
        chk_flag("other page", 1'b1, e);
        chk_data("other page data", 32'h0, r);
        apb(1, 8'h07, 6'h20, 32'h5);
        chk_flag("unmapped", 1'b1, e);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_data("phase after reset", 32'h0, {16'h0, phase_a});
        apb(0, 8'h07, 6'h0C, 0);
        chk_data("offset after reset", 32'h0, r);
        results();
    end
endmodule
